/* common/tape_xstat_pkg.sv */
// shared constants, commands and carrier types of the tape extended status block
package tape_xstat_pkg;

   // ==========================================================
   // word layout
   localparam int WORD_W     = 16;
   localparam int NUM_WORDS  = 4;
   localparam int IDX_W      = 3;
   localparam logic [IDX_W-1:0] FIRST_MSG_INDEX = 3'h3;   // fourth message word, counted from zero

   // word 0
   localparam int W0_FILE_MARK   = 15;
   localparam int W0_SHORT_REC   = 14;
   localparam int W0_LOGICAL_END = 13;
   localparam int W0_LONG_REC    = 12;
   localparam int W0_WP_ERROR    = 11;
   localparam int W0_NOT_EXEC    = 10;
   localparam int W0_BAD_CMD     = 9;
   localparam int W0_BAD_ADDR    = 8;
   localparam int W0_MOVED       = 7;
   localparam int W0_READY       = 6;
   localparam int W0_IRQ_ECHO    = 5;
   localparam int W0_MEDIA_CHG   = 4;
   localparam int W0_PE_CAPABLE  = 3;
   localparam int W0_WP          = 2;
   localparam int W0_LOAD_POINT  = 1;
   localparam int W0_TAPE_END    = 0;
   // word 1
   localparam int W1_DATA_LATE   = 15;
   localparam int W1_HARD_ERR    = 1;
   // word 2
   localparam int W2_MOVING      = 15;
   // word 3
   localparam int W3_NO_TRANS    = 6;
   localparam int W3_BACKWARD    = 5;
   localparam int W3_DENSITY_MISS = 3;
   localparam int W3_BACKED_LP   = 0;

   localparam logic [WORD_W-1:0] ZERO_WORD = 16'h0000;

   // ==========================================================
   // termination classes
   localparam logic [2:0] TC_NONE   = 3'h0;
   localparam logic [2:0] TC_ATTN   = 3'h1;
   localparam logic [2:0] TC_ALERT  = 3'h2;
   localparam logic [2:0] TC_REJECT = 3'h3;
   localparam logic [2:0] TC_RECOV  = 3'h4;
   localparam logic [2:0] TC_FATAL  = 3'h6;

   // ==========================================================
   // tape lengths without data transitions, in foot ticks
   localparam int READ_NO_TRANS_FEET  = 25;
   localparam int WRITE_NO_TRANS_FEET = 4;
   localparam int FOOT_W              = 5;
   localparam logic [FOOT_W-1:0] READ_FEET_LIMIT  = FOOT_W'(READ_NO_TRANS_FEET);
   localparam logic [FOOT_W-1:0] WRITE_FEET_LIMIT = FOOT_W'(WRITE_NO_TRANS_FEET);

   // ==========================================================
   // commands and carriers
   typedef enum logic [3:0] {
      CMD_GET_STATUS       = 4'h0,
      CMD_DRIVE_INIT       = 4'h1,
      CMD_READ             = 4'h2,
      CMD_WRITE            = 4'h3,
      CMD_WRITE_MARK       = 4'h4,
      CMD_WRITE_MARK_RETRY = 4'h5,
      CMD_SPACE            = 4'h6,
      CMD_SKIP_MARKS       = 4'h7,
      CMD_REWIND           = 4'h8,
      CMD_SET_CHAR         = 4'h9,
      CMD_WRITE_RETRY      = 4'hA,
      CMD_READ_RETRY       = 4'hB
   } cmd_code_t;

   typedef struct packed {
      logic      issue;
      cmd_code_t code;
      logic      reverse;
      logic      clear_media_change;
      logic      irq_enable;
      logic      attn_enable;
      logic      lte_enable;
      logic      addr_too_wide;
      logic      pointer_overflow;
      logic      odd_address;
      logic      bad_code;
   } cmd_t;

   typedef struct packed {
      logic done;
      logic tape_mark;
      logic record_short;
      logic record_long;
      logic stopped_early;
      logic double_mark;
      logic first_mark_off_lp;
      logic read_buffer_full;
      logic write_buffer_empty;
      logic data_error;
   } events_t;

   typedef struct packed {
      logic online;
      logic write_locked;
      logic load_point;
      logic tape_end;
      logic moving;
      logic id_burst;
      logic data_transition;
      logic foot_tick;
   } transport_t;

   typedef struct packed {
      logic              valid;
      logic [IDX_W-1:0]  index;
      logic [WORD_W-1:0] data;
      logic [2:0]        term_class;
   } msg_t;

   typedef enum logic [2:0] {
      WR_IDLE = 3'h0,
      WR_W0   = 3'h1,
      WR_W1   = 3'h3,
      WR_W2   = 3'h2,
      WR_W3   = 3'h6
   } wr_state_t;

endpackage : tape_xstat_pkg

/* src/tape_xstat.sv */
// tape extended status words and their delivery into the host message buffer
`timescale 1ns/1ps
// Summary of operation
// RULE_01 - four status words go out as message words four to seven on completion or attention
// RULE_02 - file mark flag with class 2 on mark seen or write-mark command issued
// RULE_03 - short record or early stop gives class 2; long record flag likewise
// RULE_04 - logical end only when enabled during skip marks, on double or first mark
// RULE_05 - write on locked drive gives class 3; lock during write gives class 6
// RULE_06 - not executable, class 3: reverse at load point, media change, offline, locked write
// RULE_07 - unsupported command or mode code sets bad command flag, class 2
// RULE_08 - wide address, pointer overflow or odd address sets bad address flag, class 3
// RULE_09 - tape moved during operation sets moved flag, class 3
// RULE_10 - drive ready shown; change gives attention class 1 (code: class 3, as the change also sets media change); motion while not ready class 3
// RULE_11 - interrupt enable echo follows latest issued command
// RULE_12 - media change set on online change or init, class 3; cleared by command bit
// RULE_13 - phase encoding capable always one; write protected follows the mounted tape
// RULE_14 - load point and tape end shown; reverse or rewind from load point class 3
// RULE_15 - initialization clears the tape end flag
// RULE_16 - data late, class 4, on read buffer full or write buffer empty
// RULE_17 - hard data error during read or write gives class 4
// RULE_18 - every unused bit of words one to three reads zero
// RULE_19 - tape moving flag shows motion in progress
// RULE_20 - no transitions over 25 feet reading or 4 feet writing, class 6
// RULE_21 - backward flag set for reverse motion, cleared for rewind or forward motion
// RULE_22 - missing id burst off load point flagged; reverse into load point class 2 and stop
module tape_xstat (
   input  wire logic                        CLK,
   input  wire logic                        RESET_N,
   input  wire logic                        INIT,
   input  wire tape_xstat_pkg::transport_t  TRANSPORT,
   input  wire tape_xstat_pkg::cmd_t        CMD,
   input  wire tape_xstat_pkg::events_t     EVENTS,
   input  wire logic                        MSG_READY,
   output tape_xstat_pkg::msg_t             MSG,
   output logic                             STOP_MOTION,
   output logic                             MSG_BUSY
);
   import tape_xstat_pkg::*;

   // ==========================================================
   // state
   typedef struct packed {
      transport_t       s1;
      transport_t       s2;
      transport_t       s3;
      transport_t       filt;
      transport_t       prev;
      logic             file_mark;
      logic             short_rec;
      logic             logical_end;
      logic             long_rec;
      logic             wp_error;
      logic             not_exec;
      logic             bad_cmd;
      logic             bad_addr;
      logic             moved;
      logic             irq_echo;
      logic             media_chg;
      logic             tape_end;
      logic             data_late;
      logic             hard_err;
      logic             no_trans;
      logic             backward;
      logic             density_miss;
      logic             backed_lp;
      logic             id_seen;
      logic             op_active;
      cmd_code_t        op_code;
      logic             lte_armed;
      logic             attn_enable;
      logic [FOOT_W-1:0] feet;
      logic [2:0]       op_class;
      logic             pending;
      logic [2:0]       pend_class;
      wr_state_t        wr;
      logic [NUM_WORDS-1:0][WORD_W-1:0] snap;
      msg_t             msg;
      logic             stop;
   } xstate_t;

   xstate_t st;
   xstate_t next_st;

   // ==========================================================
   // helpers
   function automatic logic is_motion(input cmd_code_t c);
      return !(c == CMD_GET_STATUS || c == CMD_DRIVE_INIT || c == CMD_SET_CHAR);
   endfunction : is_motion

   function automatic logic is_write(input cmd_code_t c);
      return c == CMD_WRITE || c == CMD_WRITE_RETRY || c == CMD_WRITE_MARK || c == CMD_WRITE_MARK_RETRY;
   endfunction : is_write

   function automatic logic is_read_type(input cmd_code_t c);
      return c == CMD_READ || c == CMD_READ_RETRY || c == CMD_SPACE || c == CMD_SKIP_MARKS;
   endfunction : is_read_type

   function automatic logic [2:0] tc_max(input logic [2:0] a, input logic [2:0] b);
      return (a > b) ? a : b;
   endfunction : tc_max

   function automatic logic [IDX_W-1:0] word_index(input wr_state_t w);
      unique case (w)
         WR_W1:   return FIRST_MSG_INDEX + 3'h1;
         WR_W2:   return FIRST_MSG_INDEX + 3'h2;
         WR_W3:   return FIRST_MSG_INDEX + 3'h3;
         default: return FIRST_MSG_INDEX;
      endcase
   endfunction : word_index

   // ==========================================================
   // word assembly
   logic [NUM_WORDS-1:0][WORD_W-1:0] words;

   always_comb begin
      words = '{default: ZERO_WORD};   // see RULE_18
      words[0][W0_FILE_MARK]   = st.file_mark;
      words[0][W0_SHORT_REC]   = st.short_rec;
      words[0][W0_LOGICAL_END] = st.logical_end;
      words[0][W0_LONG_REC]    = st.long_rec;
      words[0][W0_WP_ERROR]    = st.wp_error;
      words[0][W0_NOT_EXEC]    = st.not_exec;
      words[0][W0_BAD_CMD]     = st.bad_cmd;
      words[0][W0_BAD_ADDR]    = st.bad_addr;
      words[0][W0_MOVED]       = st.moved;
      words[0][W0_READY]       = st.filt.online;         // see RULE_10
      words[0][W0_IRQ_ECHO]    = st.irq_echo;
      words[0][W0_MEDIA_CHG]   = st.media_chg;
      words[0][W0_PE_CAPABLE]  = 1'b1;                   // see RULE_13
      words[0][W0_WP]          = st.filt.write_locked;   // see RULE_13
      words[0][W0_LOAD_POINT]  = st.filt.load_point;     // see RULE_14
      words[0][W0_TAPE_END]    = st.tape_end;            // see RULE_14
      words[1][W1_DATA_LATE]   = st.data_late;
      words[1][W1_HARD_ERR]    = st.hard_err;
      words[2][W2_MOVING]      = st.filt.moving;         // see RULE_19
      words[3][W3_NO_TRANS]    = st.no_trans;
      words[3][W3_BACKWARD]    = st.backward;
      words[3][W3_DENSITY_MISS] = st.density_miss;
      words[3][W3_BACKED_LP]   = st.backed_lp;
   end

   // ==========================================================
   // next state
   logic [$bits(transport_t)-1:0] agree;
   logic             rise_lp;
   logic             fall_lp;
   logic             lock_rise;
   logic             foot_edge;
   logic             ready_change;
   logic             attention;
   logic             finish;
   logic [2:0]       cls;
   logic [FOOT_W-1:0] feet_limit;

   always_comb begin
      next_st = st;
      cls     = st.op_class;

      // pin inputs: a bit moves only when stages two and three agree
      next_st.s1 = TRANSPORT;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      agree      = ~(st.s2 ^ st.s3);
      next_st.filt = transport_t'((agree & st.s3) | (~agree & st.filt));
      next_st.prev = st.filt;

      rise_lp      = st.filt.load_point & ~st.prev.load_point;
      fall_lp      = ~st.filt.load_point & st.prev.load_point;
      lock_rise    = st.filt.write_locked & ~st.prev.write_locked;
      foot_edge    = st.filt.foot_tick & ~st.prev.foot_tick;
      ready_change = st.filt.online ^ st.prev.online;
      feet_limit   = is_write(st.op_code) ? WRITE_FEET_LIMIT : READ_FEET_LIMIT;
      next_st.stop = 1'b0;

      // media change: set wins over the command's clear
      if (CMD.issue && CMD.clear_media_change) begin
         next_st.media_chg = 1'b0;                               // see RULE_12
      end
      if (ready_change) begin
         next_st.media_chg = 1'b1;                               // see RULE_12
      end

      // tape end follows the drive, but only a fresh arrival sets it
      if (st.filt.tape_end && !st.prev.tape_end) begin
         next_st.tape_end = 1'b1;                                // see RULE_14
      end else if (!st.filt.tape_end) begin
         next_st.tape_end = 1'b0;
      end

      // id burst tracking for the density check
      if (st.filt.load_point) begin
         next_st.id_seen = 1'b0;
      end
      if (st.filt.id_burst) begin
         next_st.id_seen = 1'b1;
      end
      if (fall_lp && !st.backward && !st.id_seen && !st.filt.id_burst) begin
         next_st.density_miss = 1'b1;                            // see RULE_22
      end

      // ---- command issue ----
      if (CMD.issue) begin
         next_st.op_active   = is_motion(CMD.code);
         next_st.op_code     = CMD.code;
         next_st.lte_armed   = CMD.lte_enable && CMD.code == CMD_SKIP_MARKS;
         next_st.attn_enable = CMD.attn_enable;
         next_st.irq_echo    = CMD.irq_enable;                   // see RULE_11
         next_st.feet        = '0;
         next_st.short_rec   = 1'b0;
         next_st.logical_end = 1'b0;
         next_st.long_rec    = 1'b0;
         next_st.moved       = 1'b0;
         next_st.data_late   = 1'b0;
         next_st.hard_err    = 1'b0;
         next_st.no_trans    = 1'b0;
         next_st.backed_lp   = 1'b0;
         next_st.file_mark   = CMD.code == CMD_WRITE_MARK || CMD.code == CMD_WRITE_MARK_RETRY;   // see RULE_02
         cls = next_st.file_mark ? TC_ALERT : TC_NONE;
         next_st.wp_error = is_write(CMD.code) && st.filt.write_locked;                          // see RULE_05
         next_st.not_exec = (CMD.reverse && st.filt.load_point)                                  // see RULE_06
                          || (is_motion(CMD.code) && st.media_chg)
                          || (!st.filt.online && CMD.code != CMD_GET_STATUS && CMD.code != CMD_DRIVE_INIT)
                          || next_st.wp_error;
         next_st.bad_cmd  = CMD.bad_code;                                                        // see RULE_07
         next_st.bad_addr = CMD.addr_too_wide || CMD.pointer_overflow || CMD.odd_address;        // see RULE_08
         if (next_st.bad_cmd) begin
            cls = tc_max(cls, TC_ALERT);
         end
         if (next_st.not_exec || next_st.bad_addr || (is_motion(CMD.code) && st.media_chg)) begin
            cls = tc_max(cls, TC_REJECT);                                                        // see RULE_12
         end
         if (is_motion(CMD.code) && !st.filt.online) begin
            cls = tc_max(cls, TC_REJECT);                                                        // see RULE_10
         end
         if (st.filt.load_point && (CMD.reverse || CMD.code == CMD_REWIND)) begin
            cls = tc_max(cls, TC_REJECT);                                                        // see RULE_14
         end
         if (is_motion(CMD.code)) begin
            next_st.backward = CMD.reverse && CMD.code != CMD_REWIND;                            // see RULE_21
         end
         if (is_motion(CMD.code) && !CMD.reverse && st.filt.load_point) begin
            next_st.density_miss = 1'b0;
         end
         if (next_st.not_exec || next_st.bad_cmd || next_st.bad_addr) begin
            next_st.op_active = 1'b0;
         end
      end

      // ---- events of the running operation ----
      if (st.op_active) begin
         if (st.filt.moving) begin
            next_st.moved = 1'b1;                                // see RULE_09
            cls = tc_max(cls, TC_REJECT);
         end
         if (EVENTS.tape_mark && is_read_type(st.op_code)) begin
            next_st.file_mark = 1'b1;                            // see RULE_02
            cls = tc_max(cls, TC_ALERT);
         end
         if (EVENTS.record_short || EVENTS.stopped_early) begin
            next_st.short_rec = 1'b1;                            // see RULE_03
            cls = tc_max(cls, TC_ALERT);
         end
         if (EVENTS.record_long) begin
            next_st.long_rec = 1'b1;                             // see RULE_03
            cls = tc_max(cls, TC_ALERT);
         end
         if (st.lte_armed && (EVENTS.double_mark || EVENTS.first_mark_off_lp)) begin
            next_st.logical_end = 1'b1;                          // see RULE_04
            cls = tc_max(cls, TC_ALERT);
         end
         if (lock_rise && is_write(st.op_code)) begin
            next_st.wp_error = 1'b1;                             // see RULE_05
            cls = tc_max(cls, TC_FATAL);
         end
         if (EVENTS.read_buffer_full || EVENTS.write_buffer_empty) begin
            next_st.data_late = 1'b1;                            // see RULE_16
            cls = tc_max(cls, TC_RECOV);
         end
         if (EVENTS.data_error && (is_write(st.op_code) || is_read_type(st.op_code))) begin
            next_st.hard_err = 1'b1;                             // see RULE_17
            cls = tc_max(cls, TC_RECOV);
         end
         // distance without any flux change, counted in foot ticks
         if (st.filt.data_transition) begin
            next_st.feet = '0;
         end else if (foot_edge && st.feet != feet_limit) begin
            next_st.feet = st.feet + FOOT_W'(1);
         end
         if (st.feet == feet_limit && !st.no_trans) begin
            next_st.no_trans = 1'b1;                             // see RULE_20
            cls = tc_max(cls, TC_FATAL);
         end
         if (rise_lp && st.backward && st.op_code != CMD_REWIND) begin
            next_st.backed_lp = 1'b1;                            // see RULE_22
            next_st.stop      = 1'b1;
            cls = tc_max(cls, TC_ALERT);
         end
      end

      // ---- completion and attention ----
      attention = ready_change && st.attn_enable;                // see RULE_10
      finish    = EVENTS.done || (CMD.issue && !next_st.op_active);
      if (attention) begin
         cls = tc_max(cls, TC_ATTN);
      end
      // a standing media change keeps every report at class 3 or higher until cleared
      if (next_st.media_chg) begin
         cls = tc_max(cls, TC_REJECT);                           // see RULE_12
      end
      next_st.op_class = cls;
      if (finish) begin
         next_st.op_active = 1'b0;
      end

      // initialization aborts the operation
      if (INIT) begin
         next_st.op_active = 1'b0;
         next_st.media_chg = 1'b1;                               // see RULE_12
         next_st.tape_end  = 1'b0;                               // see RULE_15
         next_st.op_class  = TC_NONE;
      end

      // ---- message writer; a trigger while busy is held in one pending flag, cleared by initialization ----
      if ((finish || attention) && !INIT) begin
         next_st.pending    = 1'b1;
         next_st.pend_class = cls;
      end
      unique case (st.wr)
         WR_IDLE: begin
            if (st.pending && !INIT) begin
               next_st.snap       = words;                       // see RULE_01
               next_st.msg.valid  = 1'b1;
               next_st.msg.index  = word_index(WR_W0);
               next_st.msg.data   = words[0];
               next_st.msg.term_class = st.pend_class;
               next_st.wr         = WR_W0;
               next_st.op_class   = TC_NONE;
               if (!(finish || attention)) begin
                  next_st.pending = 1'b0;
               end
            end
         end
         WR_W0, WR_W1, WR_W2: begin
            if (MSG_READY) begin
               next_st.wr        = (st.wr == WR_W0) ? WR_W1 : (st.wr == WR_W1) ? WR_W2 : WR_W3;
               next_st.msg.index = word_index(next_st.wr);
               next_st.msg.data  = st.snap[(st.wr == WR_W0) ? 1 : (st.wr == WR_W1) ? 2 : 3];
            end
         end
         WR_W3: begin
            if (MSG_READY) begin
               next_st.wr        = WR_IDLE;
               next_st.msg.valid = 1'b0;
            end
         end
         default: begin
            next_st.wr        = WR_IDLE;
            next_st.msg.valid = 1'b0;
         end
      endcase
      if (INIT) begin
         next_st.wr        = WR_IDLE;
         next_st.msg.valid = 1'b0;
         next_st.pending   = 1'b0;
      end
   end

   // ==========================================================
   // register
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         st           <= '0;
         st.media_chg <= 1'b1;
         st.wr        <= WR_IDLE;
         st.op_code   <= CMD_GET_STATUS;
      end else begin
         st <= next_st;
      end
   end

   assign MSG         = st.msg;
   assign STOP_MOTION = st.stop;
   assign MSG_BUSY    = st.wr != WR_IDLE;

endmodule : tape_xstat

/* tb/tape_xstat_asserts.sv */
// concurrent checks on the ports of the tape extended status block
`timescale 1ns/1ps
module tape_xstat_asserts (
   input wire logic                 CLK,
   input wire logic                 RESET_N,
   input wire logic                 INIT,
   input wire tape_xstat_pkg::cmd_t CMD,
   input wire logic                 MSG_READY,
   input wire tape_xstat_pkg::msg_t MSG,
   input wire logic                 MSG_BUSY
);
   import tape_xstat_pkg::*;
   // ==========================================
   // message delivery and word contents
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   a_first_word: assert property ($rose(MSG.valid) |-> MSG.index == FIRST_MSG_INDEX)
      else $error("first word not at index 3");
   a_word_order: assert property (MSG.valid && MSG_READY && MSG.index != 3'h6 && !INIT
      |=> MSG.valid && MSG.index == $past(MSG.index) + 3'h1) else $error("words out of order");
   a_word_stands: assert property (MSG.valid && !MSG_READY && !INIT |=> $stable(MSG))
      else $error("word changed before it was taken");
   // status request answers two edges later when idle
   a_status_answer: assert property ((CMD.issue && CMD.code == CMD_GET_STATUS && !MSG_BUSY && !INIT) ##1 !INIT
      |=> MSG.valid) else $error("status request got no message");
   a_pe_always: assert property (MSG.valid && MSG.index == 3'h3 |-> MSG.data[W0_PE_CAPABLE])
      else $error("phase encoding bit low");
   a_word1_zero: assert property (MSG.valid && MSG.index == 3'h4 |-> (MSG.data & 16'h7ffd) == ZERO_WORD)
      else $error("unused word 1 bit set");
   a_word3_zero: assert property (MSG.valid && MSG.index == 3'h6 |-> (MSG.data & 16'hff96) == ZERO_WORD)
      else $error("unused word 3 bit set");
   a_mark_class: assert property (MSG.valid && MSG.index == 3'h3 && MSG.data[W0_FILE_MARK]
      |-> MSG.term_class >= TC_ALERT) else $error("file mark class too low");
   a_addr_class: assert property (MSG.valid && MSG.index == 3'h3 && MSG.data[W0_BAD_ADDR]
      |-> MSG.term_class >= TC_REJECT) else $error("bad address class too low");
endmodule : tape_xstat_asserts
bind tape_xstat tape_xstat_asserts tape_xstat_asserts_inst (.*);

/* tb/tape_drive_model.sv */
// far side model: drive pins and a host memory that takes message words
`timescale 1ns/1ps
module tape_drive_model (
   input  wire logic                       clk,
   input  wire logic                       slow,
   input  wire tape_xstat_pkg::transport_t pins,
   input  wire tape_xstat_pkg::msg_t       msg,
   output tape_xstat_pkg::transport_t      transport,
   output logic                            msg_ready,
   output logic [15:0]                     words [tape_xstat_pkg::NUM_WORDS],
   output logic [2:0]                      cls,
   output int                              taken
);
   import tape_xstat_pkg::*;
   logic [1:0] stall = 2'h0;
   initial begin
      taken = 0;
      msg_ready = 1'b0;
      transport = '0;
   end
   // slow host accepts only half the time, so words must stand
   always @(posedge clk) begin
      stall <= stall + 2'h1;
      transport <= pins;
      msg_ready <= !slow || stall[1];
      if (msg.valid && msg_ready) begin
         words[msg.index - FIRST_MSG_INDEX] <= msg.data;
         cls <= msg.term_class;
         taken <= taken + 1;
      end
   end
endmodule : tape_drive_model

/* tb/tape_xstat_bench.sv */
// self-checking bench for the tape extended status block
`timescale 1ns/1ps
module tape_xstat_bench;
   import tape_xstat_pkg::*;
   localparam logic [15:0] RDY = (16'h0001 << W0_READY) | (16'h0001 << W0_PE_CAPABLE);
   logic              CLK = 1'b0;
   logic              RESET_N = 1'b0;
   logic              INIT = 1'b0;
   logic              slow = 1'b0;
   transport_t        pins = '{online: 1'b1, default: 1'b0};
   cmd_t              cmd = '0;
   events_t           events = '0;
   transport_t        transport;
   logic              msg_ready;
   msg_t              msg;
   logic [WORD_W-1:0] words [NUM_WORDS];
   logic [2:0]        cls;
   int                taken;
   int                errors = 0;
   int                compares = 0;
   always #50 CLK = ~CLK;
   tape_xstat tape_xstat_inst (.CLK(CLK), .RESET_N(RESET_N), .INIT(INIT), .TRANSPORT(transport), .CMD(cmd),
      .EVENTS(events), .MSG_READY(msg_ready), .MSG(msg), .STOP_MOTION(), .MSG_BUSY());
   tape_drive_model tape_drive_model_inst (.clk(CLK), .slow(slow), .pins(pins), .msg(msg),
      .transport(transport), .msg_ready(msg_ready), .words(words), .cls(cls), .taken(taken));
   task automatic end_of_test;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_of_test
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // opt packs clear media change, irq enable, odd address, bad code
   task automatic run(input cmd_code_t code, input logic [3:0] opt, input events_t ev,
                      input logic [15:0] w0, input logic [15:0] w1, input logic [2:0] tc);
      cmd_t c;
      events_t e;
      int base;
      c = '0;
      c.issue = 1'b1;
      c.code = code;
      {c.clear_media_change, c.irq_enable, c.odd_address, c.bad_code} = opt;
      base = taken;
      cmd <= c;
      @(posedge CLK) cmd <= '0;
      if (ev.done) begin
         e = ev;
         e.done = 1'b0;
         repeat (3) @(posedge CLK);
         events <= e;
         @(posedge CLK) events <= events_t'{done: 1'b1, default: 1'b0};
         @(posedge CLK) events <= '0;
      end
      for (int i = 0; i < 300 && taken < base + 4; i++) @(posedge CLK);
      if (taken < base + 4) begin
         errors++;
         end_of_test();
      end
      for (int i = 0; i < NUM_WORDS; i++) check("word", words[i], i == 0 ? w0 : i == 1 ? w1 : ZERO_WORD);
      check("class", 16'(cls), 16'(tc));
   endtask : run
   task automatic power_up_status;
      run(CMD_GET_STATUS, 4'b0100, '0, RDY | 16'h0030, ZERO_WORD, TC_REJECT);
      run(CMD_GET_STATUS, 4'b1000, '0, RDY, ZERO_WORD, TC_NONE);
   endtask : power_up_status
   task automatic write_mark_slow;
      slow <= 1'b1;
      run(CMD_WRITE_MARK, 4'h0, events_t'{done: 1'b1, default: 1'b0}, RDY | 16'h8000, ZERO_WORD, TC_ALERT);
      slow <= 1'b0;
   endtask : write_mark_slow
   task automatic bad_requests;
      run(CMD_GET_STATUS, 4'b0001, '0, RDY | 16'h0200, ZERO_WORD, TC_ALERT);
      run(CMD_READ, 4'b0010, '0, RDY | 16'h0100, ZERO_WORD, TC_REJECT);
   endtask : bad_requests
   task automatic data_faults;
      run(CMD_READ, 4'h0, events_t'{read_buffer_full: 1'b1, done: 1'b1, default: 1'b0}, RDY, 16'h8000, TC_RECOV);
      run(CMD_WRITE, 4'h0, events_t'{data_error: 1'b1, done: 1'b1, default: 1'b0}, RDY, 16'h0002, TC_RECOV);
   endtask : data_faults
   task automatic locked_write;
      pins.write_locked <= 1'b1;
      repeat (8) @(posedge CLK);
      run(CMD_WRITE, 4'h0, '0, RDY | 16'h0c04, ZERO_WORD, TC_REJECT);
      pins.write_locked <= 1'b0;
   endtask : locked_write
   task automatic offline_request;
      pins.online <= 1'b0;
      repeat (8) @(posedge CLK);
      run(CMD_READ, 4'h0, '0, 16'h0418, ZERO_WORD, TC_REJECT);
      pins.online <= 1'b1;
      repeat (8) @(posedge CLK);
      run(CMD_GET_STATUS, 4'b1000, '0, RDY, ZERO_WORD, TC_NONE);
   endtask : offline_request
   task automatic init_pulse;
      INIT <= 1'b1;
      @(posedge CLK) INIT <= 1'b0;
      run(CMD_GET_STATUS, 4'h0, '0, RDY | 16'h0010, ZERO_WORD, TC_REJECT);
   endtask : init_pulse
   initial begin
      repeat (3) @(posedge CLK);
      RESET_N <= 1'b1;
      repeat (10) @(posedge CLK);
      power_up_status();
      write_mark_slow();
      bad_requests();
      data_faults();
      locked_write();
      offline_request();
      init_pulse();
      end_of_test();
   end
endmodule : tape_xstat_bench
